/* include/arf_defines.svh */
`ifndef ARF_DEFINES_SVH
`define ARF_DEFINES_SVH

// Clock rate and the slowest serial rate.
`define ARF_CLK_HZ 125000000
`define ARF_BAUD_MIN 300

// Setup word fields.
`define ARF_SW1_CNT 1:0
`define ARF_SW1_MODE 4:2
`define ARF_SW1_BAUD 10:8
`define ARF_SW2_LEN 11:0
`define ARF_SW2_DIG 14:12
`define ARF_SW3_END 14:8
`define ARF_SW4_DELIM 14:8

// Field codes.
`define ARF_CNT_FOUR 2'h3
`define ARF_MODE_REPORT 3'h1
`define ARF_DIG_FOUR 3'h2

// Example setup words loaded into the controller at reset.
`define ARF_SW1_RST 16'h0007
`define ARF_SW2_RST 16'h2032
`define ARF_SW3_RST 16'h0d00
`define ARF_SW4_RST 16'h3a00

// Characters.
`define ARF_CHR_DEL 8'h7f
`define ARF_CHR_BS 8'h08
`define ARF_CHR_NUL 8'h00
`define ARF_DIGIT_HI 4'h3
`define ARF_HEX_ALPHA 8'h37

// Sizes.
`define ARF_WORD_W 16
`define ARF_FIFO_DEPTH 16
`define ARF_RXBUF_CHARS 7'h40
`define ARF_MSG_WORDS 6'h20

// Controller register map.
`define ARF_REG_CTRL 8'h00
`define ARF_REG_STATUS 8'h01
`define ARF_REG_MSGLEN 8'h02
`define ARF_REG_SETUP_HI 6'h01
`define ARF_REG_MSG_HI 3'h1
`define ARF_REG_RXD_HI 3'h2

`endif

/* include/arf_link_if.sv */
interface arf_link_if;
    // Block write transfer, controller to module.
    logic bw_valid;
    logic bw_ready;
    logic bw_last;
    logic [15:0] bw_data;
    // Block read transfer, module to controller.
    logic br_valid;
    logic br_ready;
    logic br_last;
    logic [15:0] br_data;

    modport dev (
        input bw_valid, bw_last, bw_data, br_ready,
        output bw_ready, br_valid, br_last, br_data
    );
    modport ctl (
        output bw_valid, bw_last, bw_data, br_ready,
        input bw_ready, br_valid, br_last, br_data
    );
endinterface

/* include/arf_pkg.sv */
package arf_pkg;

    typedef enum logic [2:0] {
        arf_f_fetch = 3'h0,
        arf_f_upper = 3'h1,
        arf_f_lower = 3'h3,
        arf_f_bcd = 3'h2,
        arf_f_drain = 3'h6
    } arf_fmt_t;

    typedef enum logic {
        arf_r_collect = 1'b0,
        arf_r_send = 1'b1
    } arf_rx_t;

    typedef enum logic [1:0] {
        arf_h_idle = 2'h0,
        arf_h_setup = 2'h1,
        arf_h_msg = 2'h3
    } arf_host_t;

    typedef struct packed {
        logic [15:0] sw1;
        logic [15:0] sw2;
        logic [15:0] sw3;
        logic [15:0] sw4;
        logic [2:0] idx;
        logic configured;
        arf_fmt_t fmt;
        logic [15:0] w;
        logic wlast;
        logic bcd;
        logic [1:0] dig;
        logic [7:0] tx_char;
        logic tx_valid;
        arf_rx_t rx;
        logic [63:0][7:0] rxbuf;
        logic [6:0] cnt;
        logic [7:0] pend;
        logic pend_v;
        logic [4:0] widx;
        logic [15:0] br_word;
        logic [19:0] baud_cnt;
        logic baud_tick;
    } arf_dev_st_t;

    typedef struct packed {
        logic [3:0][15:0] setup;
        logic [31:0][15:0] msg;
        logic [5:0] msglen;
        logic [31:0][15:0] rxd;
        logic [5:0] rxcnt;
        logic rx_done;
        arf_host_t st;
        logic [5:0] idx;
        logic [15:0] bw_data;
        logic [15:0] rdata;
    } arf_ctl_st_t;

endpackage

/* rtl/arf_ctrl_end.sv */
`include "arf_defines.svh"

module arf_ctrl_end (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Backplane link.
    arf_link_if.ctl lnk,
    // Software port.
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata
);
    arf_pkg::arf_ctl_st_t st_ff;
    arf_pkg::arf_ctl_st_t nxt;
    logic [1:0] wcnt;
    logic [5:0] len_m1;
    logic idle;
    logic bw_last_i;

    assign wcnt = st_ff.setup[0][`ARF_SW1_CNT];
    assign len_m1 = st_ff.msglen - 6'h01;
    assign idle = st_ff.st == arf_pkg::arf_h_idle;
    // The block ends after the setup words plus msglen message words.
    assign bw_last_i = (st_ff.st == arf_pkg::arf_h_msg
        && st_ff.idx == len_m1)
        || (st_ff.st == arf_pkg::arf_h_setup
        && st_ff.idx[1:0] == wcnt && st_ff.msglen == 6'h00); // RQ9

    assign lnk.bw_valid = !idle;
    assign lnk.bw_data = st_ff.bw_data;
    assign lnk.bw_last = bw_last_i;
    assign lnk.br_ready = ~st_ff.rx_done; // RQ10
    assign rdata = st_ff.rdata;

    always_comb begin
        nxt = st_ff;
        nxt.rdata = 16'h0000;
        // Register writes; length, setup and message are frozen while a block is sent.
        if (wr) begin
            if (addr == `ARF_REG_STATUS && wdata[1]) begin
                nxt.rx_done = 1'b0;
                nxt.rxcnt = 6'h00;
            end
            if (idle && addr == `ARF_REG_MSGLEN) begin
                nxt.msglen = (wdata > 16'(`ARF_MSG_WORDS))
                    ? `ARF_MSG_WORDS : wdata[5:0];
            end
            if (idle && addr[7:2] == `ARF_REG_SETUP_HI) begin
                nxt.setup[addr[1:0]] = wdata;
            end
            if (idle && addr[7:5] == `ARF_REG_MSG_HI) begin
                nxt.msg[addr[4:0]] = wdata; // RQ11
            end
        end
        if (rd) begin
            if (addr == `ARF_REG_STATUS) begin
                nxt.rdata = {2'b00, st_ff.rxcnt, 6'h00, st_ff.rx_done, !idle};
            end else if (addr == `ARF_REG_MSGLEN) begin
                nxt.rdata = {10'h000, st_ff.msglen};
            end else if (addr[7:2] == `ARF_REG_SETUP_HI) begin
                nxt.rdata = st_ff.setup[addr[1:0]];
            end else if (addr[7:5] == `ARF_REG_MSG_HI) begin
                nxt.rdata = st_ff.msg[addr[4:0]];
            end else if (addr[7:5] == `ARF_REG_RXD_HI) begin
                nxt.rdata = st_ff.rxd[addr[4:0]];
            end
        end
        // Block write transfer: setup words, then the message.
        unique case (st_ff.st)
            arf_pkg::arf_h_idle: begin
                if (wr && addr == `ARF_REG_CTRL && wdata[0]) begin
                    nxt.st = arf_pkg::arf_h_setup;
                    nxt.idx = 6'h00;
                    nxt.bw_data = st_ff.setup[0];
                end
            end
            arf_pkg::arf_h_setup: begin
                if (lnk.bw_ready) begin // RQ10
                    if (st_ff.idx[1:0] != wcnt) begin
                        nxt.idx = st_ff.idx + 6'h01;
                        nxt.bw_data = st_ff.setup[st_ff.idx[1:0] + 2'h1];
                    end else if (st_ff.msglen == 6'h00) begin
                        nxt.st = arf_pkg::arf_h_idle;
                    end else begin
                        nxt.st = arf_pkg::arf_h_msg;
                        nxt.idx = 6'h00;
                        nxt.bw_data = st_ff.msg[0];
                    end
                end
            end
            arf_pkg::arf_h_msg: begin
                if (lnk.bw_ready) begin
                    if (st_ff.idx == len_m1) begin
                        nxt.st = arf_pkg::arf_h_idle; // RQ9
                    end else begin
                        nxt.idx = st_ff.idx + 6'h01;
                        nxt.bw_data = st_ff.msg[st_ff.idx[4:0] + 5'h01];
                    end
                end
            end
            default: nxt.st = arf_pkg::arf_h_idle;
        endcase
        // Block read transfer; a completion outranks a clear.
        if (lnk.br_valid && !st_ff.rx_done) begin
            if (st_ff.rxcnt != `ARF_MSG_WORDS) begin
                nxt.rxd[st_ff.rxcnt[4:0]] = lnk.br_data;
                nxt.rxcnt = st_ff.rxcnt + 6'h01;
            end
            if (lnk.br_last) begin
                nxt.rx_done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.setup <= {`ARF_SW4_RST, `ARF_SW3_RST,
                `ARF_SW2_RST, `ARF_SW1_RST}; // RQ1
        end else begin
            st_ff <= nxt;
        end
    end
endmodule // arf_ctrl_end

/* rtl/arf_module_end.sv */
// Summary of operation
// [RQ1] Word one 0007: report mode, four words, 300 baud
// [RQ2] Word two 2032: four digits per word, 32 chars
// [RQ3] Word three 0D00: carriage return ends strings
// [RQ4] Word four 3A00: colon marks packed BCD
// [RQ5] Delimiters bracket BCD words, expanded as digits
// [RQ6] Controller ends each message with end marker; arf_ctrl_end sends the msg words as written and appends none
// [RQ7] Delete removes last buffered terminal character
// [RQ8] Deletes stop at the current string start
// [RQ9] Write block length covers setup plus message
// [RQ10] Controller keeps the transfer handshakes
// [RQ11] Two characters per word, upper byte first
// [RQ12] No feature acts before setup arrives
// [RQ13] Full string goes out when next char arrives
// [RQ14] String length is three BCD digits, bits 11:0
// [RQ15] Word four features need four setup words
//
// Chosen here: the address map and strobed register access.
`include "arf_defines.svh"

module arf_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } arf_fifo_st_t;

    arf_fifo_st_t st_ff;
    arf_fifo_st_t nxt;
    logic full;

    assign full = (st_ff.wr[AW] != st_ff.rd[AW])
        && (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]);
    assign in_ready = ~full;
    assign out_valid = st_ff.wr != st_ff.rd;
    assign out_data = st_ff.mem[st_ff.rd[AW-1:0]];

    always_comb begin
        nxt = st_ff;
        if (in_valid && !full) begin
            nxt.mem[st_ff.wr[AW-1:0]] = in_data;
            nxt.wr = st_ff.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            nxt.rd = st_ff.rd + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt;
        end
    end
endmodule // arf_fifo

module arf_module_end #(
    parameter int BAUD_DIV = `ARF_CLK_HZ / `ARF_BAUD_MIN
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Backplane link.
    arf_link_if.dev lnk,
    // Characters to the terminal.
    output logic [7:0] tx_char,
    output logic tx_valid,
    input wire logic tx_ready,
    // Characters from the terminal.
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    output logic rx_ready,
    // Status.
    output logic configured,
    output logic report_mode,
    output logic baud_tick
);
    arf_pkg::arf_dev_st_t st_ff;
    arf_pkg::arf_dev_st_t nxt;
    logic setup_phase;
    logic [1:0] wcnt;
    logic [16:0] f_data;
    logic f_valid;
    logic f_pop;
    logic f_in_ready;
    logic delim_on;
    logic [7:0] delim;
    logic [7:0] str_end;
    logic [1:0] dig_top;
    logic [9:0] len_bin;
    logic [6:0] limit;
    logic br_last_i;
    logic [19:0] baud_div;
    logic can_go;
    logic emit;
    logic word_end;
    logic msg_end;
    logic load_word;
    logic [7:0] chr;
    logic [3:0] nib;

    function automatic logic [15:0] arf_pair(
        input logic [63:0][7:0] b,
        input logic [6:0] n,
        input logic [4:0] w
    );
        logic [6:0] i;
        logic [7:0] hi;
        logic [7:0] lo;
        i = {1'b0, w, 1'b0};
        hi = (i < n) ? b[i[5:0]] : `ARF_CHR_NUL;
        lo = ((i + 7'h01) < n) ? b[i[5:0] + 6'h01] : `ARF_CHR_NUL;
        return {hi, lo}; // RQ11
    endfunction

    assign setup_phase = (st_ff.idx == 3'h0)
        || (st_ff.idx <= {1'b0, st_ff.sw1[`ARF_SW1_CNT]});
    assign wcnt = (st_ff.idx == 3'h0) ? lnk.bw_data[`ARF_SW1_CNT]
        : st_ff.sw1[`ARF_SW1_CNT];
    // A new setup waits until the previous message has left the path.
    assign lnk.bw_ready = setup_phase
        ? (~f_valid && st_ff.fmt == arf_pkg::arf_f_fetch) : f_in_ready;

    arf_fifo #(
        .WIDTH(`ARF_WORD_W + 1),
        .DEPTH(`ARF_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(lnk.bw_valid && !setup_phase),
        .in_ready(f_in_ready),
        .in_data({lnk.bw_last, lnk.bw_data}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    assign report_mode = st_ff.configured
        && st_ff.sw1[`ARF_SW1_MODE] == `ARF_MODE_REPORT; // RQ1
    assign delim_on = report_mode
        && st_ff.sw1[`ARF_SW1_CNT] == `ARF_CNT_FOUR; // RQ15
    assign delim = {1'b0, st_ff.sw4[`ARF_SW4_DELIM]}; // RQ4
    assign str_end = {1'b0, st_ff.sw3[`ARF_SW3_END]}; // RQ3
    assign dig_top = (st_ff.sw2[`ARF_SW2_DIG] == `ARF_DIG_FOUR)
        ? 2'h3 : 2'h2; // RQ2
    assign len_bin = 10'(st_ff.sw2[11:8]) * 10'h064
        + 10'(st_ff.sw2[7:4]) * 10'h00a + 10'(st_ff.sw2[3:0]); // RQ14
    assign limit = (len_bin == 10'h000 || len_bin > 10'(`ARF_RXBUF_CHARS))
        ? `ARF_RXBUF_CHARS : len_bin[6:0];
    assign br_last_i = ({1'b0, st_ff.widx, 1'b0} + 7'h02) >= st_ff.cnt;
    assign baud_div = 20'(BAUD_DIV) >> st_ff.sw1[`ARF_SW1_BAUD]; // RQ1

    assign tx_char = st_ff.tx_char;
    assign tx_valid = st_ff.tx_valid;
    assign rx_ready = st_ff.configured
        && st_ff.rx == arf_pkg::arf_r_collect; // RQ12
    assign lnk.br_valid = st_ff.rx == arf_pkg::arf_r_send;
    assign lnk.br_data = st_ff.br_word;
    assign lnk.br_last = lnk.br_valid && br_last_i;
    assign configured = st_ff.configured;
    assign baud_tick = st_ff.baud_tick;

    always_comb begin
        nxt = st_ff;
        f_pop = 1'b0;
        emit = 1'b0;
        word_end = 1'b0;
        msg_end = 1'b0;
        load_word = 1'b0;
        chr = `ARF_CHR_NUL;
        nib = st_ff.w[{st_ff.dig, 2'b00} +: 4];
        can_go = ~st_ff.tx_valid || tx_ready;
        if (st_ff.tx_valid && tx_ready) begin
            nxt.tx_valid = 1'b0;
        end
        // Setup words open every block write.
        if (lnk.bw_valid && lnk.bw_ready) begin
            if (lnk.bw_last) begin
                nxt.idx = 3'h0;
            end else if (st_ff.idx != 3'h7) begin
                nxt.idx = st_ff.idx + 3'h1;
            end
            if (setup_phase) begin
                unique case (st_ff.idx[1:0])
                    2'h0: nxt.sw1 = lnk.bw_data;
                    2'h1: nxt.sw2 = lnk.bw_data;
                    2'h2: nxt.sw3 = lnk.bw_data;
                    2'h3: nxt.sw4 = lnk.bw_data;
                endcase
                if (st_ff.idx[1:0] == wcnt) begin
                    nxt.configured = 1'b1; // RQ12
                end
            end
        end
        // Message formatter.
        unique case (st_ff.fmt)
            arf_pkg::arf_f_fetch: begin
                if (st_ff.configured && f_valid) begin // RQ12
                    f_pop = 1'b1;
                    nxt.w = f_data[15:0];
                    nxt.wlast = f_data[16];
                    if (!st_ff.bcd) begin
                        nxt.fmt = arf_pkg::arf_f_upper;
                    end else if (f_data[15:8] == delim) begin
                        nxt.bcd = 1'b0; // RQ5
                        nxt.fmt = arf_pkg::arf_f_lower;
                    end else begin
                        nxt.fmt = arf_pkg::arf_f_bcd;
                        nxt.dig = dig_top; // RQ2
                    end
                end
            end
            arf_pkg::arf_f_upper, arf_pkg::arf_f_lower: begin
                if (can_go) begin
                    chr = (st_ff.fmt == arf_pkg::arf_f_upper)
                        ? st_ff.w[15:8] : st_ff.w[7:0]; // RQ11
                    if (chr == str_end) begin
                        emit = 1'b1;
                        msg_end = 1'b1; // RQ6
                    end else if (delim_on && chr == delim) begin
                        nxt.bcd = 1'b1; // RQ5
                        word_end = 1'b1;
                    end else begin
                        emit = chr != `ARF_CHR_NUL;
                        if (st_ff.fmt == arf_pkg::arf_f_upper) begin
                            nxt.fmt = arf_pkg::arf_f_lower;
                        end else begin
                            word_end = 1'b1;
                        end
                    end
                end
            end
            arf_pkg::arf_f_bcd: begin
                if (can_go) begin
                    emit = 1'b1;
                    chr = (nib < 4'ha) ? {`ARF_DIGIT_HI, nib}
                        : `ARF_HEX_ALPHA + {4'h0, nib}; // RQ5
                    if (st_ff.dig == 2'h0) begin
                        word_end = 1'b1;
                    end else begin
                        nxt.dig = st_ff.dig - 2'h1;
                    end
                end
            end
            arf_pkg::arf_f_drain: begin
                if (f_valid) begin
                    f_pop = 1'b1;
                    if (f_data[16]) begin
                        nxt.fmt = arf_pkg::arf_f_fetch;
                    end
                end
            end
            default: nxt.fmt = arf_pkg::arf_f_fetch;
        endcase
        if (emit) begin
            nxt.tx_char = chr;
            nxt.tx_valid = 1'b1;
        end
        if (word_end) begin
            nxt.fmt = arf_pkg::arf_f_fetch;
            if (st_ff.wlast) begin
                nxt.bcd = 1'b0;
            end
        end
        // Words after the end marker are dropped up to the block end.
        if (msg_end) begin
            nxt.bcd = 1'b0;
            nxt.fmt = st_ff.wlast ? arf_pkg::arf_f_fetch
                : arf_pkg::arf_f_drain; // RQ6
        end
        // Terminal input buffer.
        unique case (st_ff.rx)
            arf_pkg::arf_r_collect: begin
                if (rx_valid && rx_ready) begin
                    if (rx_char == `ARF_CHR_DEL || rx_char == `ARF_CHR_BS)
                    begin
                        if (st_ff.cnt != 7'h00) begin
                            nxt.cnt = st_ff.cnt - 7'h01; // RQ7 RQ8
                        end
                    end else if (st_ff.cnt >= limit) begin
                        nxt.pend = rx_char; // RQ13
                        nxt.pend_v = 1'b1;
                        nxt.rx = arf_pkg::arf_r_send;
                        nxt.widx = 5'h00;
                        load_word = 1'b1;
                    end else begin
                        nxt.rxbuf[st_ff.cnt[5:0]] = rx_char;
                        nxt.cnt = st_ff.cnt + 7'h01;
                        if (rx_char == str_end) begin
                            nxt.rx = arf_pkg::arf_r_send; // RQ3
                            nxt.widx = 5'h00;
                            load_word = 1'b1;
                        end
                    end
                end
            end
            arf_pkg::arf_r_send: begin
                if (lnk.br_ready) begin
                    if (br_last_i) begin
                        nxt.rx = arf_pkg::arf_r_collect;
                        nxt.cnt = st_ff.pend_v ? 7'h01 : 7'h00;
                        nxt.rxbuf[0] = st_ff.pend;
                        nxt.pend_v = 1'b0;
                    end else begin
                        nxt.widx = st_ff.widx + 5'h01;
                        load_word = 1'b1;
                    end
                end
            end
        endcase
        if (load_word) begin
            nxt.br_word = arf_pair(nxt.rxbuf, nxt.cnt, nxt.widx); // RQ11
        end
        // Serial rate enable.
        nxt.baud_tick = 1'b0;
        if (st_ff.configured) begin
            if (st_ff.baud_cnt >= baud_div - 20'h00001) begin
                nxt.baud_cnt = 20'h00000;
                nxt.baud_tick = 1'b1;
            end else begin
                nxt.baud_cnt = st_ff.baud_cnt + 20'h00001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt;
        end
    end
endmodule // arf_module_end

/* tb/arf_link_checker.sv */
module arf_link_checker (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Block write transfer.
    input wire logic bw_valid,
    input wire logic bw_ready,
    input wire logic bw_last,
    input wire logic [15:0] bw_data,
    // Block read transfer.
    input wire logic br_valid,
    input wire logic br_ready,
    input wire logic br_last,
    input wire logic [15:0] br_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [5:0] bw_cnt_ff;
    logic [5:0] nxt_bw_cnt;
    always_comb begin
        nxt_bw_cnt = bw_cnt_ff;
        if (bw_valid && bw_ready) begin
            nxt_bw_cnt = bw_last ? 6'h00 : bw_cnt_ff + 6'h01;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bw_cnt_ff <= 6'h00;
        end else begin
            bw_cnt_ff <= nxt_bw_cnt;
        end
    end
    property p_idle;
        $rose(rstn) |-> !bw_valid && !br_valid && br_ready;
    endproperty
    a_idle: assert property (p_idle) else $error("link busy at reset");
    property p_bw_hold;
        bw_valid && !bw_ready |=> bw_valid && $stable(bw_data);
    endproperty
    a_bw_hold: assert property (p_bw_hold)
        else $error("write word moved");
    property p_bw_end;
        bw_valid && bw_ready && bw_last |=> !bw_valid;
    endproperty
    a_bw_end: assert property (p_bw_end) else $error("write past last");
    property p_bw_four;
        bw_valid && bw_ready && bw_last |-> bw_cnt_ff >= 6'h03;
    endproperty
    a_bw_four: assert property (p_bw_four) else $error("short block");
    property p_br_hold;
        br_valid && !br_ready |=> br_valid && $stable(br_data);
    endproperty
    a_br_hold: assert property (p_br_hold)
        else $error("read word moved");
    property p_br_end;
        br_valid && br_ready && br_last |=> !br_valid && !br_ready;
    endproperty
    a_br_end: assert property (p_br_end) else $error("read past last");
    property p_br_upper;
        br_valid |-> br_data[15:8] != 8'h00;
    endproperty
    a_br_upper: assert property (p_br_upper)
        else $error("empty upper");
    property p_bw_go;
        bw_valid |-> ##[0:1000] bw_ready;
    endproperty
    a_bw_go: assert property (p_bw_go) else $error("write stuck");
endmodule // arf_link_checker

/* tb/ascii_report_formatter_tb.sv */
module ascii_report_formatter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic tx_ready = 1'b0;
    logic [7:0] rx_char = 8'h00;
    logic rx_valid = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] tx_char;
    logic tx_valid, rx_ready, configured, report_mode, baud_tick;
    logic [15:0] rdata, st;
    int n_mismatch = 0;
    int total_checks = 0;
    int ticks = 0;
    logic [7:0] got_tx[$];
    logic [7:0] exp_tx[$];
    logic [15:0] sw_exp[4] = '{16'h0007, 16'h2032, 16'h0d00, 16'h3a00};
    logic [15:0] msg4[4] = '{16'h4142, 16'h413a, 16'h12ab, 16'h3a00};
    arf_link_if lnk();
    arf_module_end #(.BAUD_DIV(8)) arf_module_end_inst (.ref_clk, .rstn,
        .lnk(lnk), .tx_char, .tx_valid, .tx_ready, .rx_char, .rx_valid,
        .rx_ready, .configured, .report_mode, .baud_tick);
    arf_ctrl_end arf_ctrl_end_inst (.ref_clk, .rstn, .lnk(lnk), .addr,
        .wdata, .wr, .rd, .rdata);
    arf_link_checker arf_link_checker_inst (.ref_clk, .rstn,
        .bw_valid(lnk.bw_valid), .bw_ready(lnk.bw_ready),
        .bw_last(lnk.bw_last), .bw_data(lnk.bw_data),
        .br_valid(lnk.br_valid), .br_ready(lnk.br_ready),
        .br_last(lnk.br_last), .br_data(lnk.br_data));
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got_tx.push_back(tx_char);
        if (baud_tick === 1'b1) ticks++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 st = rdata;
    endtask
    task automatic poll(input logic [15:0] mask, input logic [15:0] val);
        for (int i = 0; i < 2000; i++) begin
            rd_reg(8'h01);
            if ((st & mask) === val) return;
        end
        // A status that never arrives counts against the run.
        n_mismatch++;
    endtask
    task automatic rx_send(input logic [7:0] c);
        @(posedge ref_clk);
        rx_char <= c;
        rx_valid <= 1'b1;
        do @(negedge ref_clk); while (rx_ready !== 1'b1);
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
    endtask
    task automatic close_out();
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd_reg(8'h04 + i[7:0]);
            check(st, sw_exp[i]);
        end
        rd_reg(8'h10);
        check(st, 16'h0000);
        check({14'h0000, configured, rx_ready}, 16'h0000);
        wr_reg(8'h05, 16'h2003);
        for (int i = 0; i < 20; i++) begin
            wr_reg(8'h20 + i[7:0], i < 4 ? msg4[i & 3] :
                (i == 19 ? 16'h450d : 16'h4344));
        end
        wr_reg(8'h02, 16'h0014);
        wr_reg(8'h00, 16'h0001);
        repeat (200) @(posedge ref_clk);
        rd_reg(8'h01);
        check(st & 16'h0001, 16'h0001);
        check({14'h0000, configured, report_mode}, 16'h0003);
        ticks = 0;
        repeat (80) @(posedge ref_clk);
        #1 check(ticks[15:0], 16'h000a);
        tx_ready <= 1'b1;
        poll(16'h0001, 16'h0000);
        // Up to sixteen buffered words still drain after the block ends.
        repeat (200) @(posedge ref_clk);
        exp_tx = '{8'h41, 8'h42, 8'h41, 8'h31, 8'h32, 8'h41, 8'h42};
        for (int i = 0; i < 15; i++) begin
            exp_tx.push_back(8'h43);
            exp_tx.push_back(8'h44);
        end
        exp_tx.push_back(8'h45);
        exp_tx.push_back(8'h0d);
        check(16'(got_tx.size()), 16'(exp_tx.size()));
        foreach (exp_tx[i]) begin
            check({8'h00, got_tx[i]}, {8'h00, exp_tx[i]});
        end
        for (int i = 0; i < 4; i++) rx_send(8'h61 + i[7:0]);
        poll(16'h0002, 16'h0002);
        check(st & 16'h3f02, 16'h0202);
        rd_reg(8'h40);
        check(st, 16'h6162);
        rd_reg(8'h41);
        check(st, 16'h6300);
        wr_reg(8'h01, 16'h0002);
        rx_send(8'h58);
        rx_send(8'h7f);
        rx_send(8'h0d);
        poll(16'h0002, 16'h0002);
        rd_reg(8'h40);
        check(st, 16'h640d);
        // The done flag is left set so that the next string must wait.
        rx_send(8'h59);
        rx_send(8'h08);
        rx_send(8'h08);
        rx_send(8'h51);
        rx_send(8'h0d);
        wr_reg(8'h01, 16'h0002);
        poll(16'h0002, 16'h0002);
        rd_reg(8'h40);
        check(st, 16'h510d);
        close_out();
    end
endmodule // ascii_report_formatter_tb
